// file: lcd_cmd_consts.vh
`ifndef LCD_CMD_CONSTS_VH
`define LCD_CMD_CONSTS_VH
// Avalon register word addresses (byte address / 4).
`define REG_CMD_ADDR      4'h0
`define REG_DATA_ADDR     4'h1
`define REG_STATUS_ADDR   4'h2
`define REG_DISPLAY_ADDR  4'h3
`define REG_SCROLL_ADDR   4'h4
`define REG_MODE_ADDR     4'h5
`define REG_PIXEL_ADDR    4'h6
// Opcode patterns (command byte, upper bits compared under mask).
`define OP_PAGE           8'hB0
`define OP_COL_HI         8'h10
`define OP_COL_LO         8'h00
`define OP_MOD_SET        8'hE0
`define OP_MOD_CLR        8'hEE
`define OP_DISP           8'hAE
`define OP_START_LINE     8'h40
`define OP_FIRST_ROW      8'h44
`define OP_PARTIAL        8'h48
`define OP_NLINE          8'h4C
`define OP_NLINE_REL      8'hE4
`define OP_REVERSE        8'hA6
`define OP_ALL_DARK       8'hA4
`define OP_POWER          8'h28
// Limits and reset values.
`define COL_LAST          8'h9F
`define RATIO_MIN         8'h10
`define RATIO_MAX         8'h80
`define RATIO_CAP_MODE1   8'h64
`define RESET_RATIO       8'h80
`define GRAY_DARK         4'hF
`endif

// file: lcd_display_command_decoder.v
// Overview of operation
// - Column advances after each data write and each read outside modify-read
// - Column built from high and low nibbles
// - Modify-read stops read increment only
// - Leaving modify-read restores saved column
// - Display off overrides all-dark and reverse
// - Commands still execute while display off
// - Two-byte command sets start line
// - Two-byte command sets first common row
// - Partial ratio 16 to 128, else ignored
// - Symbol row shifts ratio range up one
// - Inversion code gives frame or n+2 lines
// - Release command returns frame inversion
// - Reverse maps gray g to 15-g
// - All-dark forces every pixel dark
// - All-dark wins over reverse
// - Three power bits enable three circuits
// - Write increment wraps column to zero
// - Page command loads pages 0 to 15
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cmd_consts.vh"
module lcd_display_command_decoder (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        symbol_row,
  input  wire        duty_mode1,
  input  wire [3:0]  ram_gray,
  output reg  [3:0]  pixel_gray,
  output reg         panel_enable,
  output reg  [7:0]  column_index,
  output reg  [3:0]  page_index,
  output reg  [6:0]  start_line_value,
  output reg  [6:0]  first_row_value,
  output reg  [7:0]  partial_ratio_value,
  output reg  [4:0]  inversion_code,
  output reg         converter_enable,
  output reg         regulator_enable,
  output reg         follower_enable,
  output reg         data_wr_pulse,
  output reg         data_rd_pulse
);

  // One-hot record of which parameter byte the next command write is.
  localparam [4:0] P_NONE  = 5'b00001;
  localparam [4:0] P_START = 5'b00010;
  localparam [4:0] P_ROW   = 5'b00100;
  localparam [4:0] P_RATIO = 5'b01000;
  localparam [4:0] P_NLINE = 5'b10000;

  // Mode latches and the pending-parameter state.
  reg [4:0] param_q;
  reg       modify_q;
  reg [7:0] saved_col_q;
  reg       display_on_q;
  reg       reverse_gray_bit;
  reg       force_all_dark_bit;
  reg [7:0] wdata;
  reg       access_q;

  // The strap pair and the RAM gray code cross from outside the clock domain.
  reg [1:0] sym_s1_q;
  reg [1:0] sym_s2_q;
  reg [3:0] gray_s1_q;
  reg [3:0] gray_s2_q;

  // Column increment with wrap after the last column.
  // A column set past the last one also wraps, so it never runs away.
  function [7:0] next_col;
    input [7:0] c;
    begin
      if (c >= `COL_LAST) begin
        next_col = 8'h00;
      end else begin
        next_col = c + 8'h01;
      end
    end
  endfunction

  // Ratio acceptance window, shifted up by one with the symbol row.
  // The cap for mode 1 is applied by the caller, not here.
  function ratio_ok;
    input [7:0] v;
    input       sym;
    begin
      if (sym) begin
        ratio_ok = (v >= `RATIO_MIN + 8'h01) && (v <= `RATIO_MAX + 8'h01);
      end else begin
        ratio_ok = (v >= `RATIO_MIN) && (v <= `RATIO_MAX);
      end
    end
  endfunction

  // Only the low byte of a bus word carries a command or parameter.
  always @* begin
    wdata = avs_writedata[7:0];
  end

  // Two-stage synchronisers for the strap-like inputs and RAM gray code.
  // Only the second stage is read, as the first may still be settling.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sym_s1_q  <= 2'b00;
      sym_s2_q  <= 2'b00;
      gray_s1_q <= 4'h0;
      gray_s2_q <= 4'h0;
    end else begin
      sym_s1_q  <= {duty_mode1, symbol_row};
      sym_s2_q  <= sym_s1_q;
      gray_s1_q <= ram_gray;
      gray_s2_q <= gray_s1_q;
    end
  end

  // Avalon slave: every access waits exactly one cycle, then completes.
  // The fixed wait state gives read data a cycle to be registered,
  // at the cost of two edges per access.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      access_q        <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && !access_q) begin
      access_q        <= 1'b1;
      avs_waitrequest <= 1'b0;
    end else begin
      access_q        <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
  end

  // Command interpreter and data-port address counter.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      param_q             <= P_NONE;
      modify_q            <= 1'b0;
      saved_col_q         <= 8'h00;
      display_on_q        <= 1'b0;
      reverse_gray_bit    <= 1'b0;
      force_all_dark_bit  <= 1'b0;
      column_index        <= 8'h00;
      page_index          <= 4'h0;
      start_line_value    <= 7'h00;
      first_row_value     <= 7'h00;
      partial_ratio_value <= `RESET_RATIO;
      inversion_code      <= 5'h00;
      converter_enable    <= 1'b0;
      regulator_enable    <= 1'b0;
      follower_enable     <= 1'b0;
      data_wr_pulse       <= 1'b0;
      data_rd_pulse       <= 1'b0;
      avs_readdata        <= 32'h0000_0000;
    end else begin
      // Strobes idle low and are raised for one cycle below.
      data_wr_pulse <= 1'b0;
      data_rd_pulse <= 1'b0;
      if (access_q && avs_write) begin
        if (avs_address == `REG_CMD_ADDR) begin
          if (param_q != P_NONE) begin
            param_q <= P_NONE;
            case (param_q)
              P_START: begin
                start_line_value <= wdata[6:0];
              end
              P_ROW: begin
                first_row_value <= wdata[6:0];
              end
              P_RATIO: begin
                if (ratio_ok(wdata, sym_s2_q[0])) begin
                  if (sym_s2_q[1] && wdata > `RATIO_CAP_MODE1) begin
                    partial_ratio_value <= `RATIO_CAP_MODE1;
                  end else begin
                    partial_ratio_value <= wdata;
                  end
                end
              end
              P_NLINE: begin
                inversion_code <= wdata[4:0];
              end
              default: begin
                // Unreachable with one-hot codes; falls back to idle.
                param_q <= P_NONE;
              end
            endcase
          end else if ((wdata & 8'hF0) == `OP_PAGE) begin
            page_index <= wdata[3:0];
          end else if ((wdata & 8'hF0) == `OP_COL_HI) begin
            column_index <= {wdata[3:0], column_index[3:0]};
          end else if ((wdata & 8'hF0) == `OP_COL_LO) begin
            column_index <= {column_index[7:4], wdata[3:0]};
          end else if (wdata == `OP_MOD_SET) begin
            // enter modify-read
            // Re-entering takes a fresh snapshot of the column.
            modify_q    <= 1'b1;
            saved_col_q <= column_index;
          end else if (wdata == `OP_MOD_CLR) begin
            if (modify_q) column_index <= saved_col_q;
            modify_q <= 1'b0;
          end else if ((wdata & 8'hFE) == `OP_DISP) begin
            display_on_q <= wdata[0];
          end else if ((wdata & 8'hFC) == `OP_START_LINE) begin
            param_q <= P_START;
          end else if ((wdata & 8'hFC) == `OP_FIRST_ROW) begin
            param_q <= P_ROW;
          end else if ((wdata & 8'hFC) == `OP_PARTIAL) begin
            param_q <= P_RATIO;
          end else if ((wdata & 8'hFC) == `OP_NLINE) begin
            param_q <= P_NLINE;
          end else if (wdata == `OP_NLINE_REL) begin
            inversion_code <= 5'h00;
          end else if ((wdata & 8'hFE) == `OP_REVERSE) begin
            reverse_gray_bit <= wdata[0];
          end else if ((wdata & 8'hFE) == `OP_ALL_DARK) begin
            force_all_dark_bit <= wdata[0];
          end else if ((wdata & 8'hF8) == `OP_POWER) begin
            converter_enable <= wdata[2];
            regulator_enable <= wdata[1];
            follower_enable  <= wdata[0];
          end
        end else if (avs_address == `REG_DATA_ADDR) begin
          column_index  <= next_col(column_index);
          data_wr_pulse <= 1'b1;
        end
      end
      // Read data is loaded as waitrequest drops, so it already stands at
      // the edge where the master samples waitrequest low.
      if (avs_read && !access_q) begin
        if (avs_address == `REG_STATUS_ADDR) begin
          avs_readdata <= {26'h0, param_q[4], |param_q[3:1],
                           modify_q, force_all_dark_bit,
                           reverse_gray_bit, display_on_q};
        end else if (avs_address == `REG_DISPLAY_ADDR) begin
          avs_readdata <= {12'h0, page_index, 8'h0, column_index};
        end else if (avs_address == `REG_SCROLL_ADDR) begin
          avs_readdata <= {1'b0, first_row_value, 1'b0, start_line_value,
                           partial_ratio_value, 3'h0, inversion_code};
        end else if (avs_address == `REG_MODE_ADDR) begin
          avs_readdata <= {29'h0, converter_enable, regulator_enable,
                           follower_enable};
        end else if (avs_address == `REG_PIXEL_ADDR) begin
          avs_readdata <= {28'h0, pixel_gray};
        end else begin
          // The data port has no RAM behind it here, so it reads as zero.
          avs_readdata <= 32'h0000_0000;
        end
      end
      // Data-port read side effects land on the completing edge.
      if (access_q && avs_read && avs_address == `REG_DATA_ADDR) begin
        data_rd_pulse <= 1'b1;
        if (!modify_q) column_index <= next_col(column_index);
      end
    end
  end

  // Pixel mapping: display-off blanks, all-dark wins over reverse.
  // A register here keeps the panel outputs free of decode glitches.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pixel_gray   <= 4'h0;
      panel_enable <= 1'b0;
    end else begin
      panel_enable <= display_on_q;
      if (!display_on_q) begin
        pixel_gray <= 4'h0;
      end else if (force_all_dark_bit) begin
        pixel_gray <= `GRAY_DARK;
      end else if (reverse_gray_bit) begin
        pixel_gray <= `GRAY_DARK - gray_s2_q;
      end else begin
        pixel_gray <= gray_s2_q;
      end
    end
  end

endmodule // lcd_display_command_decoder
`default_nettype wire

// file: ram_pixel_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the display RAM read port feeding the pixel mapper.
module ram_pixel_model (
  input  wire logic       clk,
  input  wire logic [3:0] next_gray,
  output var  logic [3:0] ram_gray
);
  // Steps only on the clock, so the synchroniser sees clean changes.
  always @(posedge clk) ram_gray <= next_gray;
endmodule // ram_pixel_model
`default_nettype wire

// file: lcd_cmd_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Watches bus timing and decoded levels from outside the decoder.
module lcd_cmd_checker (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [3:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [3:0] pixel_gray,
  input wire logic       panel_enable,
  input wire logic [7:0] column_index,
  input wire logic [3:0] page_index,
  input wire logic [6:0] start_line_value,
  input wire logic [7:0] partial_ratio_value,
  input wire logic       converter_enable,
  input wire logic       regulator_enable,
  input wire logic       follower_enable,
  input wire logic       data_wr_pulse,
  input wire logic       data_rd_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Completed command and data-port writes, and data-port reads.
  wire cmd_done = avs_write && !avs_waitrequest && avs_address == 4'h0;
  wire dat_done = avs_write && !avs_waitrequest && avs_address == 4'h1;
  wire rd_done = avs_read && !avs_waitrequest && avs_address == 4'h1;
  a_wr_pulse: assert property (
    dat_done |=> data_wr_pulse) else $error("write strobe missing");
  a_rd_pulse: assert property (
    rd_done |=> data_rd_pulse) else $error("read strobe missing");
  a_strobe_once: assert property (
    data_wr_pulse || data_rd_pulse |=> !data_wr_pulse && !data_rd_pulse)
    else $error("strobe held too long");
  a_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request left unanswered");
  a_wait_short: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
  a_col_advance: assert property (
    dat_done |=> column_index == (($past(column_index) == 8'h9F) ? 8'h00
      : $past(column_index) + 8'h01)) else $error("column step wrong");
  a_col_cause: assert property (
    $changed(column_index) |-> $past(!avs_waitrequest)
      && $past(avs_read || avs_write)) else $error("column moved alone");
  a_page_cause: assert property (
    $changed(page_index) |-> $past(cmd_done)) else $error("page moved alone");
  a_line_cause: assert property (
    $changed(start_line_value) |-> $past(cmd_done))
    else $error("start line moved alone");
  a_power_cause: assert property (
    $changed({converter_enable, regulator_enable, follower_enable})
      |-> $past(cmd_done)) else $error("power moved alone");
  a_ratio_range: assert property (
    $changed(partial_ratio_value) |-> partial_ratio_value inside
      {[8'h10:8'h81]}) else $error("ratio out of range");
  a_off_dark: assert property (
    !panel_enable && $past(!panel_enable) |-> pixel_gray == 4'h0)
    else $error("pixel shown while off");
  c_data_write: cover property (dat_done);
  c_panel_on: cover property ($rose(panel_enable));
  c_ratio_set: cover property ($changed(partial_ratio_value));
endmodule // lcd_cmd_checker
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cmd_consts.vh"
module testbench;
  logic        clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0;
  logic        avs_write = 1'b0, symbol_row = 1'b0, duty_mode1 = 1'b0;
  logic        avs_waitrequest, panel_enable, converter_enable;
  logic        regulator_enable, follower_enable;
  logic        data_wr_pulse, data_rd_pulse;
  logic [3:0]  avs_address = 4'h0, next_gray = 4'h0, ram_gray;
  logic [3:0]  pixel_gray, page_index, px;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rnd;
  logic [7:0]  column_index, partial_ratio_value, ratio;
  logic [6:0]  start_line_value, first_row_value, line, row;
  logic [4:0]  inversion_code, inv;
  logic [31:0] q[$];
  integer      errors = 0, num_checks = 0, seed = 32'h642f, i;
  // Ratio cases: symbol row, mode 1, value sent, ratio expected after.
  logic [17:0] tbl [8] = '{18'h0_0F80, 18'h0_1010, 18'h0_8110,
    18'h0_8080, 18'h2_1080, 18'h2_8181, 18'h1_7F64, 18'h1_1111};
  lcd_display_command_decoder uut (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .symbol_row(symbol_row),
    .duty_mode1(duty_mode1), .ram_gray(ram_gray), .pixel_gray(pixel_gray),
    .panel_enable(panel_enable), .column_index(column_index),
    .page_index(page_index), .start_line_value(start_line_value),
    .first_row_value(first_row_value), .inversion_code(inversion_code),
    .partial_ratio_value(partial_ratio_value),
    .converter_enable(converter_enable), .follower_enable(follower_enable),
    .regulator_enable(regulator_enable), .data_wr_pulse(data_wr_pulse),
    .data_rd_pulse(data_rd_pulse));
  ram_pixel_model pm (.clk(clk), .next_gray(next_gray), .ram_gray(ram_gray));
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  // Holds the request until wait is seen low, then idles one cycle.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic cmd(input logic [7:0] d);
    bus(1'b1, 4'h0, 32'(d));
  endtask
  function automatic logic [31:0] f4();
    return {1'b0, row, 1'b0, line, ratio, 3'b000, inv};
  endfunction
  // Data-port reads return zero here and are not queued, so only register reads compare.
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest && avs_address != 4'h1)
      chk(avs_readdata, q.pop_front());
  end
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Bounds a hang; the tests need well under a tenth of this.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    ratio = 8'h80;
    row = 7'h00;
    line = 7'h00;
    inv = 5'h00;
    bus(1'b1, 4'hF, 32'h0000_00FF);
    rd(4'h2, 32'h0000_0000);
    rd(4'h3, 32'h0000_0000);
    rd(4'h4, f4());
    rd(4'h5, 32'h0000_0000);
    rd(4'hF, 32'h0000_0000);
    $display("reset test done");
    cmd(`OP_PAGE | 8'h0F);
    cmd(`OP_COL_HI | 8'h09);
    cmd(`OP_COL_LO | 8'h0F);
    rd(4'h3, 32'h000F_009F);
    bus(1'b1, 4'h1, 32'h0000_005A);
    rd(4'h3, 32'h000F_0000);
    bus(1'b0, 4'h1, 32'h0000_0000);
    rd(4'h3, 32'h000F_0001);
    $display("column test done");
    cmd(`OP_COL_LO | 8'h02);
    cmd(`OP_MOD_SET);
    rd(4'h2, 32'h0000_0008);
    bus(1'b0, 4'h1, 32'h0000_0000);
    bus(1'b1, 4'h1, 32'h0000_00A5);
    rd(4'h3, 32'h000F_0003);
    cmd(`OP_MOD_CLR);
    rd(4'h3, 32'h000F_0002);
    $display("modify test done");
    // A parameter byte that looks like display-on must stay a parameter.
    cmd(`OP_START_LINE);
    cmd(8'hAF);
    line = 7'h2F;
    rnd = $random(seed);
    row = rnd[6:0];
    inv = rnd[12:8] | 5'h01;
    cmd(`OP_FIRST_ROW);
    cmd({1'b1, row});
    cmd(`OP_NLINE);
    cmd({3'b111, inv});
    rd(4'h4, f4());
    rd(4'h2, 32'h0000_0000);
    cmd(`OP_NLINE_REL);
    inv = 5'h00;
    rd(4'h4, f4());
    $display("two byte test done");
    for (i = 0; i < 8; i++) begin
      {symbol_row, duty_mode1} <= tbl[i][17:16];
      repeat (3) @(posedge clk);
      cmd(`OP_PARTIAL);
      cmd(tbl[i][15:8]);
      ratio = tbl[i][7:0];
      rd(4'h4, f4());
    end
    $display("ratio test done");
    for (i = 0; i < 8; i++) begin
      rnd = $random(seed);
      next_gray <= rnd[3:0];
      cmd(`OP_DISP | {7'h00, i[0]});
      cmd(`OP_REVERSE | {7'h00, i[1]});
      cmd(`OP_ALL_DARK | {7'h00, i[2]});
      px = !i[0] ? 4'h0 : i[2] ? 4'hF : i[1] ? ~rnd[3:0] : rnd[3:0];
      // The mapper registers the last command one edge later.
      @(posedge clk);
      chk(32'(pixel_gray), 32'(px));
      chk(32'(panel_enable), 32'(i[0]));
      rd(4'h2, 32'(i[2:0]));
      rd(4'h6, 32'(px));
    end
    $display("display test done");
    for (i = 0; i < 8; i++) begin
      cmd(`OP_POWER | {5'h00, i[2:0]});
      rd(4'h5, 32'(i[2:0]));
      chk(32'({converter_enable, regulator_enable, follower_enable}),
          32'(i[2:0]));
    end
    $display("power test done");
    final_report;
  end
endmodule // testbench
bind lcd_display_command_decoder lcd_cmd_checker chk_i (.clk(clk),
  .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .pixel_gray(pixel_gray), .panel_enable(panel_enable),
  .column_index(column_index), .page_index(page_index),
  .start_line_value(start_line_value),
  .partial_ratio_value(partial_ratio_value),
  .converter_enable(converter_enable), .regulator_enable(regulator_enable),
  .follower_enable(follower_enable), .data_wr_pulse(data_wr_pulse),
  .data_rd_pulse(data_rd_pulse));
`default_nettype wire
